//--- hw/fpuex_params.svh
/*
 * constants for the fpu exception and status block: status bit positions,
 * operand class codes, compare codes and pointer image offsets.
 * assumes it is included by its bare name after the package.
 */
// Behaviour
// - classify top operand into one fixed c3 c2 c0 pattern per class; c1 set when negative
// - error summary bit 7 set iff any unmasked exception flag 0-5 set
// - error output active whenever error summary is set
// - stack fault flag at bit 6; bit 9 one on overflow, zero underflow
// - detected exception sets its matching flag in bits 0-5
// - each flag has its own control mask; masked yields default result
// - after unmasked exception, next fp or wait raises 16, or interrupt
// - cause priority: invalid, denormal, zero divide, overflow, underflow, inexact
// - masked defaults: nan/indefinite, infinity, largest/infinity, denormal/zero, continue
// - stack overflow or underflow reports invalid and sets stack fault
// - status load never takes bits 7 and 15; both recomputed from flags
// - error summary set after status load drives error output at once
// - each decoded fp instruction captures instruction address, operand address, opcode
// - four pointer image formats by mode and size; v86 uses real
// - operand pointer undefined when previous instruction had no memory operand
// - real 32-bit image: cw 0, sw 4, tag 8, ip c, ip/op 10
// - denormal flagged when an operand has minimum exponent, nonzero significand
// - zero divide when divisor zero and dividend finite and nonzero
// - overflow when result magnitude exceeds destination format
// - underflow on tiny nonzero result; when masked only on accuracy loss
// - inexact when result not exact; rounding follows selected mode
// - compare: greater 000, less c0, equal c3, unordered c3 c2 c0
`ifndef FPUEX_PARAMS_SVH
`define FPUEX_PARAMS_SVH

// status word fields
`define FPUEX_SW_SF       6
`define FPUEX_SW_ES       7
`define FPUEX_SW_C0       8
`define FPUEX_SW_C1       9
`define FPUEX_SW_C2       10
`define FPUEX_SW_TOP_LO   11
`define FPUEX_SW_C3       14
`define FPUEX_SW_BUSY     15
`define FPUEX_SW_RESET    16'h0000

// class codes as {c3,c2,c1,c0}, sign adds c1
`define FPUEX_CC_UNSUP    4'h0
`define FPUEX_CC_NAN      4'h1
`define FPUEX_CC_NORMAL   4'h4
`define FPUEX_CC_INF      4'h5
`define FPUEX_CC_ZERO     4'h8
`define FPUEX_CC_EMPTY    4'h9
`define FPUEX_CC_DENORM   4'hc
`define FPUEX_CC_NEG      4'h2

// compare codes as {c3,c2,c0}
`define FPUEX_CMP_GT      3'h0
`define FPUEX_CMP_LT      3'h1
`define FPUEX_CMP_EQ      3'h4
`define FPUEX_CMP_UN      3'h7

// pointer image byte offsets
`define FPUEX_IMG_CW      5'h00
`define FPUEX_IMG_SW      5'h04
`define FPUEX_IMG_TAG     5'h08
`define FPUEX_IMG_IP      5'h0c
`define FPUEX_IMG_IPHI    5'h10
`define FPUEX_IMG_OPND    5'h14
`define FPUEX_IMG_OPHI    5'h18
`define FPUEX_IMG16_CW    5'h00
`define FPUEX_IMG16_SW    5'h02
`define FPUEX_IMG16_TAG   5'h04
`define FPUEX_IMG16_IP    5'h06
`define FPUEX_IMG16_IPHI  5'h08
`define FPUEX_IMG16_OPND  5'h0a
`define FPUEX_IMG16_OPHI  5'h0c

`endif

//--- hw/fpuex_pkg.sv
/*
 * types for the fpu exception and status block.
 * assumes nothing beyond a systemverilog compiler.
 */
package fpuex_pkg;

   typedef enum logic [2:0] {
      FPUEX_CL_UNSUP  = 3'b000,
      FPUEX_CL_NAN    = 3'b001,
      FPUEX_CL_NORMAL = 3'b010,
      FPUEX_CL_INF    = 3'b011,
      FPUEX_CL_ZERO   = 3'b100,
      FPUEX_CL_EMPTY  = 3'b101,
      FPUEX_CL_DENORM = 3'b110
   } fpuex_class_e;

   typedef enum logic [1:0] {
      FPUEX_CMP_GREATER = 2'b00,
      FPUEX_CMP_LESS    = 2'b01,
      FPUEX_CMP_EQUAL   = 2'b10,
      FPUEX_CMP_UNORD   = 2'b11
   } fpuex_cmp_e;

   typedef enum logic [2:0] {
      FPUEX_ACT_NONE     = 3'b000,
      FPUEX_ACT_QNAN     = 3'b001,
      FPUEX_ACT_INF      = 3'b010,
      FPUEX_ACT_LARGEST  = 3'b011,
      FPUEX_ACT_TINY     = 3'b100,
      FPUEX_ACT_CONTINUE = 3'b101
   } fpuex_act_e;

endpackage

//--- hw/fpu_exception_status.sv
/*
 * fpu exception and status logic: condition codes, exception flags, error
 * summary, error output, pending exception signalling, pointer capture and
 * pointer image readout.
 * assumes the integer core and datapath drive strobes on sys_clk; the
 * datapath supplies the raw detection conditions and does the rounding.
 */
`timescale 1ns/1ps
`include "fpuex_params.svh"

module fpu_exception_status (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   srst,
   // control word, tag word and core mode
   input  wire logic [15:0]            controlWord,
   input  wire logic [15:0]            tagWord,
   input  wire logic                   nativeErrorMode,
   input  wire logic                   protMode,
   input  wire logic                   v86Mode,
   input  wire logic                   opSize32,
   // classify and compare
   input  wire logic                   classValid,
   input  wire fpuex_pkg::fpuex_class_e classKind,
   input  wire logic                   classNeg,
   input  wire logic                   cmpValid,
   input  wire fpuex_pkg::fpuex_cmp_e  cmpKind,
   // exception detection from the datapath
   input  wire logic                   opDone,
   input  wire logic                   invalidCause,
   input  wire logic                   stackFault,
   input  wire logic                   stackOverflow,
   input  wire logic [1:0]             srcExpMin,
   input  wire logic [1:0]             srcSigNonzero,
   input  wire logic                   divOp,
   input  wire logic                   divisorZero,
   input  wire logic                   dividendFinite,
   input  wire logic                   dividendNonzero,
   input  wire logic                   resultTooLarge,
   input  wire logic                   resultTooSmall,
   input  wire logic                   resultNonzero,
   input  wire logic                   denormLoss,
   input  wire logic                   resultInexact,
   // status word load and clear
   input  wire logic                   statusLoad,
   input  wire logic [15:0]            statusLoadData,
   input  wire logic                   flagClear,
   // instruction decode
   input  wire logic                   fpInstr,
   input  wire logic                   waitInstr,
   input  wire logic                   fpDecode,
   input  wire logic [31:0]            instrAddr,
   input  wire logic [15:0]            codeSel,
   input  wire logic [10:0]            opcode,
   input  wire logic                   hasMemOperand,
   input  wire logic [31:0]            operandAddr,
   input  wire logic [15:0]            dataSel,
   // pointer image readout
   input  wire logic [4:0]             imageOffset,
   // outputs
   output logic [15:0]                 statusWord,
   output logic                        fpu_error_out,
   output logic                        exc16Pulse,
   output logic                        extIntPulse,
   output fpuex_pkg::fpuex_act_e       defaultAction,
   output logic [31:0]                 imageData
);

   // ************************************************************
   // exception detection
   // ************************************************************
   logic [5:0]  rawCause;
   logic [5:0]  cause;
   logic [5:0]  excMask;
   logic [5:0]  excFlags;
   logic        stack_fault_flag;
   logic        error_summary;
   logic [3:0]  condCodes;
   logic [2:0]  topPtr;

   assign excMask = controlWord[5:0];

   always_comb begin
      rawCause[0] = invalidCause | stackFault;
      rawCause[1] = |(srcExpMin & srcSigNonzero);
      rawCause[2] = divOp & divisorZero & dividendFinite & dividendNonzero;
      rawCause[3] = resultTooLarge;
      // masked underflow only counts when denormalising lost bits
      rawCause[4] = resultTooSmall & resultNonzero & (~excMask[4] | denormLoss);
      rawCause[5] = resultInexact;
   end

   // later causes are dropped after invalid or zero divide, masked or not, and after an unmasked denormal
   always_comb begin
      cause = 6'h00;
      if (opDone) begin
         if (rawCause[0]) begin
            cause = 6'h01;
         end else if (rawCause[1] & ~excMask[1]) begin
            cause = 6'h02;
         end else if (rawCause[2]) begin
            cause = 6'h04;
         end else begin
            cause = rawCause & 6'h3e;
            if (rawCause[1] & excMask[1]) begin
               cause[2] = 1'b0;
            end
         end
      end
   end

   // ************************************************************
   // flags, stack fault and condition codes
   // ************************************************************
   logic [5:0]  next_excFlags;
   logic        next_errorSummary;
   logic        next_stackFault;
   logic [3:0]  next_condCodes;
   logic [2:0]  next_topPtr;

   always_comb begin
      next_excFlags = excFlags;
      if (statusLoad) begin
         next_excFlags = statusLoadData[5:0];
      end else if (flagClear) begin
         next_excFlags = 6'h00;
      end
      next_excFlags = next_excFlags | cause;
   end

   // recomputed every cycle so a mask change or a load takes effect at once
   assign next_errorSummary = |(next_excFlags & ~excMask);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         excFlags      <= 6'h00;
         error_summary <= 1'b0;
      end else begin
         excFlags      <= next_excFlags;
         error_summary <= next_errorSummary;
      end
   end

   always_comb begin
      next_stackFault = stack_fault_flag;
      if (opDone & stackFault) begin
         next_stackFault = 1'b1;
      end else if (statusLoad) begin
         next_stackFault = statusLoadData[`FPUEX_SW_SF];
      end else if (flagClear) begin
         next_stackFault = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stack_fault_flag <= 1'b0;
      end else begin
         stack_fault_flag <= next_stackFault;
      end
   end

   function automatic logic [3:0] classCode(input fpuex_pkg::fpuex_class_e k,
                                            input logic neg);
      logic [3:0] c;
      case (k)
         fpuex_pkg::FPUEX_CL_UNSUP:  c = `FPUEX_CC_UNSUP;
         fpuex_pkg::FPUEX_CL_NAN:    c = `FPUEX_CC_NAN;
         fpuex_pkg::FPUEX_CL_NORMAL: c = `FPUEX_CC_NORMAL;
         fpuex_pkg::FPUEX_CL_INF:    c = `FPUEX_CC_INF;
         fpuex_pkg::FPUEX_CL_ZERO:   c = `FPUEX_CC_ZERO;
         fpuex_pkg::FPUEX_CL_EMPTY:  c = `FPUEX_CC_EMPTY;
         fpuex_pkg::FPUEX_CL_DENORM: c = `FPUEX_CC_DENORM;
         default:                    c = `FPUEX_CC_UNSUP;
      endcase
      return neg ? (c | `FPUEX_CC_NEG) : c;
   endfunction

   // condCodes held as {c3,c2,c1,c0}
   always_comb begin
      next_condCodes = condCodes;
      if (opDone & stackFault) begin
         next_condCodes[1] = stackOverflow;
      end else if (classValid) begin
         next_condCodes = classCode(classKind, classNeg);
      end else if (cmpValid) begin
         case (cmpKind)
            fpuex_pkg::FPUEX_CMP_GREATER: next_condCodes = 4'h0;
            fpuex_pkg::FPUEX_CMP_LESS:    next_condCodes = {3'h0, 1'b1};
            fpuex_pkg::FPUEX_CMP_EQUAL:   next_condCodes = {1'b1, 3'h0};
            fpuex_pkg::FPUEX_CMP_UNORD:   next_condCodes = {2'h3, 1'b0, 1'b1};
            default:                      next_condCodes = 4'h0;
         endcase
      end else if (statusLoad) begin
         next_condCodes = {statusLoadData[`FPUEX_SW_C3], statusLoadData[`FPUEX_SW_C2],
                           statusLoadData[`FPUEX_SW_C1], statusLoadData[`FPUEX_SW_C0]};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         condCodes <= 4'h0;
      end else begin
         condCodes <= next_condCodes;
      end
   end

   assign next_topPtr = statusLoad ? statusLoadData[`FPUEX_SW_TOP_LO +: 3] : topPtr;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         topPtr <= 3'h0;
      end else if (statusLoad) begin
         topPtr <= statusLoadData[`FPUEX_SW_TOP_LO +: 3];
      end
   end

   // ************************************************************
   // status word, error output and pending exception
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         statusWord <= `FPUEX_SW_RESET;
      end else begin
         // busy mirror and summary never come from the loaded image
         // every field from its next value, so all land on the same edge
         statusWord <= {next_errorSummary, next_condCodes[3], next_topPtr,
                        next_condCodes[2:0], next_errorSummary, next_stackFault,
                        next_excFlags};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fpu_error_out <= 1'b0;
      end else begin
         // same edge as the load, so no instruction is needed to raise it
         fpu_error_out <= next_errorSummary;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         exc16Pulse  <= 1'b0;
         extIntPulse <= 1'b0;
      end else begin
         exc16Pulse  <= (fpInstr | waitInstr) & error_summary & ~nativeErrorMode;
         extIntPulse <= (fpInstr | waitInstr) & error_summary & nativeErrorMode;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         defaultAction <= fpuex_pkg::FPUEX_ACT_NONE;
      end else if (opDone) begin
         if (rawCause[0] & excMask[0]) begin
            defaultAction <= fpuex_pkg::FPUEX_ACT_QNAN;
         end else if (rawCause[1] & excMask[1]) begin
            defaultAction <= fpuex_pkg::FPUEX_ACT_CONTINUE;
         end else if (rawCause[2] & excMask[2]) begin
            defaultAction <= fpuex_pkg::FPUEX_ACT_INF;
         end else if (rawCause[3] & excMask[3]) begin
            defaultAction <= fpuex_pkg::FPUEX_ACT_LARGEST;
         end else if (rawCause[4] & excMask[4]) begin
            defaultAction <= fpuex_pkg::FPUEX_ACT_TINY;
         end else if (rawCause[5] & excMask[5]) begin
            defaultAction <= fpuex_pkg::FPUEX_ACT_CONTINUE;
         end else begin
            defaultAction <= fpuex_pkg::FPUEX_ACT_NONE;
         end
      end
   end

   // ************************************************************
   // instruction and operand pointers
   // ************************************************************
   logic [31:0] ipSave;
   logic [15:0] csSave;
   logic [10:0] opSave;
   logic [31:0] dpSave;
   logic [15:0] dsSave;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ipSave <= 32'h0;
         csSave <= 16'h0;
         opSave <= 11'h0;
      end else if (fpDecode) begin
         ipSave <= instrAddr;
         csSave <= codeSel;
         opSave <= opcode;
      end
   end

   // left stale without a memory operand; software must not rely on it
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dpSave <= 32'h0;
         dsSave <= 16'h0;
      end else if (fpDecode & hasMemOperand) begin
         dpSave <= operandAddr;
         dsSave <= dataSel;
      end
   end

   // ************************************************************
   // pointer image readout
   // ************************************************************
   logic        realFmt;
   logic [31:0] next_imageData;

   assign realFmt = ~protMode | v86Mode;

   always_comb begin
      next_imageData = 32'h0;
      if (opSize32) begin
         case (imageOffset)
            `FPUEX_IMG_CW:   next_imageData = {16'h0, controlWord};
            `FPUEX_IMG_SW:   next_imageData = {16'h0, statusWord};
            `FPUEX_IMG_TAG:  next_imageData = {16'h0, tagWord};
            `FPUEX_IMG_IP:   next_imageData = realFmt ? {16'h0, ipSave[15:0]} : ipSave;
            `FPUEX_IMG_IPHI: next_imageData = realFmt ?
                                {4'h0, ipSave[31:16], 1'b0, opSave} :
                                {5'h0, opSave, csSave};
            `FPUEX_IMG_OPND: next_imageData = realFmt ? {16'h0, dpSave[15:0]} : dpSave;
            `FPUEX_IMG_OPHI: next_imageData = realFmt ?
                                {4'h0, dpSave[31:16], 12'h0} : {16'h0, dsSave};
            default:         next_imageData = 32'h0;
         endcase
      end else begin
         case (imageOffset)
            `FPUEX_IMG16_CW:   next_imageData = {16'h0, controlWord};
            `FPUEX_IMG16_SW:   next_imageData = {16'h0, statusWord};
            `FPUEX_IMG16_TAG:  next_imageData = {16'h0, tagWord};
            `FPUEX_IMG16_IP:   next_imageData = {16'h0, ipSave[15:0]};
            `FPUEX_IMG16_IPHI: next_imageData = realFmt ?
                                  {16'h0, ipSave[19:16], 1'b0, opSave} : {16'h0, csSave};
            `FPUEX_IMG16_OPND: next_imageData = {16'h0, dpSave[15:0]};
            `FPUEX_IMG16_OPHI: next_imageData = realFmt ?
                                  {16'h0, dpSave[19:16], 12'h0} : {16'h0, dsSave};
            default:           next_imageData = 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         imageData <= 32'h0;
      end else begin
         imageData <= next_imageData;
      end
   end

endmodule

//--- verif/fpuex_chk.sv
/* assertion checker for the fpu exception and status block.
   assumes it is bound to the block and sees only its ports. */
`timescale 1ns/1ps
module fpuex_chk (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        srst,
   // block inputs
   input wire logic [15:0] controlWord,
   input wire logic        nativeErrorMode,
   input wire logic        opDone,
   input wire logic        stackFault,
   input wire logic        stackOverflow,
   input wire logic        statusLoad,
   input wire logic [15:0] statusLoadData,
   input wire logic        flagClear,
   input wire logic        fpInstr,
   input wire logic        waitInstr,
   // block outputs
   input wire logic [15:0] statusWord,
   input wire logic        fpu_error_out,
   input wire logic        exc16Pulse,
   input wire logic        extIntPulse
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   wire pendReq = (fpInstr || waitInstr) && statusWord[7];
   // ****
   // assertions
   // ****
   a_err_level: assert property (fpu_error_out == statusWord[7])
      else $error("error output differs from summary");
   a_busy_mirror: assert property (statusWord[15] == statusWord[7])
      else $error("busy mirror differs from summary");
   // mask changes reach the summary one cycle late, hence the past mask
   a_sum_flags: assert property (statusWord[7] ==
      |(statusWord[5:0] & ~$past(controlWord[5:0])))
      else $error("summary not equal to unmasked flags");
   a_stack_set: assert property (opDone && stackFault |=> statusWord[6] && statusWord[0]
      && statusWord[9] == $past(stackOverflow))
      else $error("stack fault not reported");
   a_exc_sixteen: assert property (pendReq && !nativeErrorMode |=>
      exc16Pulse && !extIntPulse)
      else $error("exception 16 not raised");
   a_ext_int: assert property (pendReq && nativeErrorMode |=>
      extIntPulse && !exc16Pulse)
      else $error("external interrupt not raised");
   a_no_pend: assert property (!pendReq |=> !exc16Pulse && !extIntPulse)
      else $error("pending pulse without cause");
   a_load_sum: assert property (statusLoad && !opDone && !flagClear |=> statusWord[5:0] ==
      $past(statusLoadData[5:0]) && fpu_error_out ==
      |($past(statusLoadData[5:0]) & ~$past(controlWord[5:0])))
      else $error("status load not recomputed");
   a_err_release: assert property (!opDone && !statusLoad &&
      !(|(statusWord[5:0] & ~controlWord[5:0])) |=> !fpu_error_out)
      else $error("error output not released");
   c_stack: cover property (opDone && stackFault);
   c_exc: cover property (exc16Pulse);
   c_int: cover property (extIntPulse);
   c_load: cover property (statusLoad);
endmodule
bind fpu_exception_status fpuex_chk i_chk (.sys_clk, .srst, .controlWord, .nativeErrorMode,
   .opDone, .stackFault, .stackOverflow, .statusLoad, .statusLoadData, .flagClear, .fpInstr,
   .waitInstr, .statusWord, .fpu_error_out, .exc16Pulse, .extIntPulse);

//--- verif/fpuex_core_model.sv
/* integer core model: starts fp and wait instructions, counts exception pulses.
   assumes the bench sets issue for one cycle at a falling edge. */
`timescale 1ns/1ps
module fpuex_core_model (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       srst,
   // bench side
   input  wire logic [1:0] issue,
   output logic [7:0]      nExc,
   output logic [7:0]      nInt,
   // block side
   output logic            fpInstr = 1'h0,
   output logic            waitInstr = 1'h0,
   input  wire logic       exc16Pulse,
   input  wire logic       extIntPulse
);
   logic [1:0] pend;
   // launch strobes at falling edges so the block samples them settled
   always @(posedge sys_clk) pend <= srst ? 2'h0 : issue;
   always @(negedge sys_clk) {waitInstr, fpInstr} <= pend;
   always @(posedge sys_clk) begin
      nExc <= srst ? 8'h0 : nExc + {7'h0, exc16Pulse};
      nInt <= srst ? 8'h0 : nInt + {7'h0, extIntPulse};
   end
endmodule

//--- verif/fpu_exception_status_tb.sv
/* self-checking bench for the fpu exception and status block.
   assumes the checker binds itself and the core model drives the start strobes. */
`timescale 1ns/1ps
module fpu_exception_status_tb;
   typedef struct packed {logic [15:0] det; logic [5:0] msk;
                          logic [7:0] sw; logic [2:0] act;} fpuex_row_s;
   logic                    sys_clk = 1'h0, srst = 1'h1;
   logic [15:0]             controlWord = 16'h037f, tagWord = 16'ha5a5, statusLoadData = 16'h0;
   logic [15:0]             det = 16'h0, codeSel = 16'h1111, dataSel = 16'h2222, statusWord;
   logic                    nativeErrorMode = 1'h0, protMode = 1'h0, v86Mode = 1'h0;
   logic                    opSize32 = 1'h1, classValid = 1'h0, classNeg = 1'h0, cmpValid = 1'h0;
   logic                    opDone = 1'h0, statusLoad = 1'h0, flagClear = 1'h0, fpDecode = 1'h0;
   logic                    hasMemOperand = 1'h1, fpu_error_out, exc16Pulse, extIntPulse;
   logic                    fpInstr, waitInstr;
   fpuex_pkg::fpuex_class_e classKind = fpuex_pkg::FPUEX_CL_UNSUP;
   fpuex_pkg::fpuex_cmp_e   cmpKind = fpuex_pkg::FPUEX_CMP_GREATER;
   fpuex_pkg::fpuex_act_e   defaultAction;
   logic [31:0]             instrAddr = 32'h12345678, operandAddr = 32'h9abcdef0, imageData;
   logic [10:0]             opcode = 11'h5a5;
   logic [4:0]              imageOffset = 5'h0;
   logic [1:0]              issue = 2'h0;
   logic [7:0]              nExc, nInt;
   int                      n_mismatch = 0, total_checks = 0;
   logic [3:0]              cc[7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hc};
   logic [2:0]              cp[4] = '{3'h0, 3'h1, 3'h4, 3'h7};
   // {prot, v86}, offset, expected word
   logic [38:0]             img[12] = '{{2'h0, 5'h00, 32'h0000037f}, {2'h0, 5'h04, 32'h0},
      {2'h0, 5'h08, 32'h0000a5a5}, {2'h0, 5'h0c, 32'h00005678}, {2'h0, 5'h10, 32'h012345a5},
      {2'h0, 5'h14, 32'h0000def0}, {2'h0, 5'h18, 32'h09abc000}, {2'h3, 5'h10, 32'h012345a5},
      {2'h2, 5'h0c, 32'h12345678}, {2'h2, 5'h10, 32'h05a51111}, {2'h2, 5'h14, 32'h9abcdef0},
      {2'h2, 5'h18, 32'h00002222}};
   fpuex_row_s              rows[16] = '{
      {16'h8000, 6'h00, 8'h81, 3'h0}, {16'h8011, 6'h00, 8'h81, 3'h0},
      {16'h8000, 6'h01, 8'h01, 3'h1}, {16'h0a00, 6'h00, 8'h82, 3'h0},
      {16'h0c00, 6'h00, 8'h00, 3'h0}, {16'h0a00, 6'h02, 8'h02, 3'h5},
      {16'h01e0, 6'h00, 8'h84, 3'h0}, {16'h01a0, 6'h00, 8'h00, 3'h0},
      {16'h01e0, 6'h04, 8'h04, 3'h2}, {16'h0011, 6'h3f, 8'h28, 3'h3},
      {16'h000c, 6'h3f, 8'h00, 3'h0}, {16'h000e, 6'h3f, 8'h10, 3'h4},
      {16'h000c, 6'h00, 8'h90, 3'h0}, {16'h0008, 6'h00, 8'h00, 3'h0},
      {16'h0001, 6'h00, 8'ha0, 3'h0}, {16'h6000, 6'h00, 8'hc1, 3'h0}};

   fpu_exception_status i_dut (.sys_clk, .srst, .controlWord, .tagWord, .nativeErrorMode,
      .protMode, .v86Mode, .opSize32, .classValid, .classKind, .classNeg, .cmpValid, .cmpKind,
      .opDone, .invalidCause(det[15]), .stackFault(det[14]), .stackOverflow(det[13]),
      .srcExpMin(det[12:11]), .srcSigNonzero(det[10:9]), .divOp(det[8]), .divisorZero(det[7]),
      .dividendFinite(det[6]), .dividendNonzero(det[5]), .resultTooLarge(det[4]),
      .resultTooSmall(det[3]), .resultNonzero(det[2]), .denormLoss(det[1]),
      .resultInexact(det[0]), .statusLoad, .statusLoadData, .flagClear, .fpInstr, .waitInstr,
      .fpDecode, .instrAddr, .codeSel, .opcode, .hasMemOperand, .operandAddr, .dataSel,
      .imageOffset, .statusWord, .fpu_error_out, .exc16Pulse, .extIntPulse, .defaultAction,
      .imageData);
   fpuex_core_model i_core (.sys_clk, .srst, .issue, .nExc, .nInt, .fpInstr, .waitInstr,
      .exc16Pulse, .extIntPulse);

   initial forever #50 sys_clk = ~sys_clk;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one start strobe through the core model, then wait for its count
   task automatic start(input logic [1:0] kind);
      issue = kind;
      tick();
      issue = 2'h0;
      tick(3);
   endtask

   // ****
   // sequence
   // ****
   initial begin
      tick(5);
      srst = 1'h0;
      fpDecode = 1'h1;
      tick();
      fpDecode = 1'h0;
      foreach (img[i]) begin
         {protMode, v86Mode, imageOffset} = img[i][38:32];
         tick();
         chk("image", imageData, img[i][31:0]);
      end
      // without a memory operand only the code side is trusted afterwards
      {opSize32, protMode, imageOffset} = 7'h08;
      tick();
      chk("image16", imageData, 32'h000045a5);
      {opSize32, protMode, v86Mode, imageOffset} = 8'h8c;
      {instrAddr, hasMemOperand, fpDecode} = {32'h0000beef, 2'h1};
      tick();
      {hasMemOperand, fpDecode} = 2'h2;
      tick();
      chk("ip", imageData, 32'h0000beef);
      $display("test image done");
      foreach (rows[i]) begin
         flagClear = 1'h1;
         tick();
         {flagClear, opDone, det, controlWord} = {2'h1, rows[i].det, 10'h0, rows[i].msk};
         tick();
         {opDone, det} = 17'h0;
         chk("flags", 32'(statusWord[7:0]), 32'(rows[i].sw));
         chk("default", 32'(defaultAction), 32'(rows[i].act));
      end
      $display("test exceptions done");
      for (int k = 0; k < 14; k++) begin
         classKind = fpuex_pkg::fpuex_class_e'(k[3:1]);
         {classNeg, classValid} = {k[0], 1'h1};
         tick();
         classValid = 1'h0;
         chk("class", 32'({statusWord[14], statusWord[10:8]}),
             32'(cc[k/2] | {k[0], 1'h0}));
      end
      for (int k = 0; k < 4; k++) begin
         cmpKind = fpuex_pkg::fpuex_cmp_e'(k[1:0]);
         cmpValid = 1'h1;
         tick();
         cmpValid = 1'h0;
         chk("compare", 32'({statusWord[14], statusWord[10], statusWord[8]}),
             32'(cp[k]));
      end
      $display("test codes done");
      {controlWord, statusLoadData, statusLoad} = {16'h003f, 16'h8081, 1'h1};
      tick();
      chk("load masked", 32'(statusWord & 16'h80bf), 32'h00000001);
      {controlWord, statusLoadData} = {16'h0, 16'h0004};
      tick();
      statusLoad = 1'h0;
      chk("load", 32'({statusWord & 16'h80bf, fpu_error_out}), 32'h00010109);
      tick();
      $display("test load done");
      start(2'h1);
      chk("pend ne0", 32'({nExc, nInt}), 32'h00000100);
      nativeErrorMode = 1'h1;
      start(2'h2);
      chk("pend ne1", 32'({nExc, nInt}), 32'h00000101);
      controlWord = 16'h003f;
      tick();
      chk("release", 32'(fpu_error_out), 32'h0);
      start(2'h1);
      chk("no pend", 32'({nExc, nInt}), 32'h00000101);
      $display("test pending done");
      srst = 1'h1;
      tick(2);
      srst = 1'h0;
      chk("reset", {statusWord, 12'h0, fpu_error_out, defaultAction}, 32'h0);
      $display("test reset done");
      give_verdict();
   end

   // the sequence needs roughly 90 cycles
   initial begin
      repeat (2000) @(posedge sys_clk);
      n_mismatch++;
      give_verdict();
   end
endmodule
